// file: hdl/frm_core.sv
// Purpose: fault flag latching, masking, roll-up and error pin drive
// Assumes: detector inputs synchronous one-cycle-or-longer levels
// Notes:   error pin is open drain: o_err_oe high pulls low
// What this block does
// RULE1 - diagnostics and own flags keep running even when masked
// RULE2 - a set mask blocks roll-up flags and error pin, not own flag
// RULE3 - masking by channel enable or by fault type, separate controls
// RULE4 - channel diag enable 0 suppresses its flags, roll-ups and pin
// RULE5 - low supply masked: own flag only, no error flag, no pin
// RULE6 - low supply unmasked: own flag, error flag, one 50 us pulse
// RULE7 - undervoltage masked: own flag only; unmasked: pin held low
// RULE8 - checksum unmasked: flag, error flag, 50 us pulse; masked: own flag only
// RULE9 - open sets own flag if channel enabled; unmasked also roll-ups and pulse
// RULE10 - short sets own flag if channel enabled; unmasked also roll-ups and pulse
// RULE11 - single led short sets own flag; unmasked roll-ups and pulse
// RULE12 - fault flags latch until cleared
// RULE13 - host writes clear strobe; bit returns to zero by itself
// RULE14 - unmasked reference fault holds pin low while present
// RULE15 - pre-thermal pulses, overtemp holds, both maskable
// RULE16 - pulse timed by clock counter, not shortened by new faults
`timescale 1ns/1ps
`default_nettype none
module frm_core (
	input  wire logic                      i_clock,
	input  wire logic                      i_srst,
	input  wire logic                      i_psel,
	input  wire logic                      i_penable,
	input  wire logic                      i_pwrite,
	input  wire logic [7:0]                i_paddr,
	input  wire logic [31:0]               i_pwdata,
	output logic      [31:0]               o_prdata,
	output logic                           o_pready,
	output logic                           o_pslverr,
	input  wire logic [frm_pkg::NUM_CH-1:0] i_open_det,
	input  wire logic [frm_pkg::NUM_CH-1:0] i_short_det,
	input  wire logic [frm_pkg::NUM_CH-1:0] i_sls_det,
	input  wire logic                      i_low_supply_det,
	input  wire logic                      i_supply_uv_det,
	input  wire logic                      i_ref_fault_det,
	input  wire logic                      i_pre_thermal_det,
	input  wire logic                      i_overtemp_det,
	input  wire logic                      i_eeprom_crc_det,
	output logic                           o_err_oe,
	output logic                           o_err_out,
	output logic                           o_any_out_flag,
	output logic                           o_global_err_flag,
	output logic                           o_irq
);
	localparam int N = frm_pkg::NUM_CH;

	logic [N-1:0]                     channel_diag_enable_q;
	logic [frm_pkg::NUM_MASK-1:0]     mask_q;
	logic [N-1:0]                     channel_open_flag_q;
	logic [N-1:0]                     channel_short_flag_q;
	logic [N-1:0]                     channel_single_led_short_flag_q;
	logic [frm_pkg::NUM_GLB-1:0]      glb_flag_q;
	logic                             out_flag_q;
	logic                             err_flag_q;
	logic                             fault_clear_strobe_q;
	logic [frm_pkg::NUM_IRQ-1:0]      irq_status_q;
	logic [frm_pkg::NUM_IRQ-1:0]      irq_mask_q;
	logic [frm_pkg::PCNT_W-1:0]       pulse_cnt_q;
	logic [N-1:0]                     open_ev;
	logic [N-1:0]                     short_ev;
	logic [N-1:0]                     sls_ev;
	logic [frm_pkg::NUM_GLB-1:0]      glb_ev;
	logic                             out_ev;
	logic                             err_ev;
	logic                             pulse_ev;
	logic                             hold_low;
	logic                             wr_acc;
	logic                             rd_acc;

	////////////////////////////////////////////////////////////////////////
	// fault events and roll-up qualification
	assign open_ev  = i_open_det & channel_diag_enable_q;   // [RULE4] [RULE1]
	assign short_ev = i_short_det & channel_diag_enable_q;  // [RULE4] [RULE1]
	assign sls_ev   = i_sls_det & channel_diag_enable_q;    // [RULE4] [RULE1]
	assign glb_ev   = {i_eeprom_crc_det, i_overtemp_det, i_pre_thermal_det,
		i_ref_fault_det, i_supply_uv_det, i_low_supply_det};
	// per-type masks on top of per-channel enables
	assign out_ev = ((|open_ev) & ~mask_q[frm_pkg::B_OPEN])      // [RULE3] [RULE9]
		| ((|short_ev) & ~mask_q[frm_pkg::B_SHORT])               // [RULE10]
		| ((|sls_ev) & ~mask_q[frm_pkg::B_SLS]);                  // [RULE11]
	assign err_ev = out_ev | (|(glb_ev & ~mask_q[frm_pkg::NUM_GLB-1:0])); // [RULE2]
	assign pulse_ev = out_ev                                               // [RULE9]
		| (i_low_supply_det & ~mask_q[frm_pkg::B_LOWSUP])                  // [RULE6] [RULE5]
		| (i_pre_thermal_det & ~mask_q[frm_pkg::B_PRETSD])                 // [RULE15]
		| (i_eeprom_crc_det & ~mask_q[frm_pkg::B_EEPCRC]);                 // [RULE8]
	assign hold_low = (i_supply_uv_det & ~mask_q[frm_pkg::B_SUPUV])        // [RULE7]
		| (i_ref_fault_det & ~mask_q[frm_pkg::B_REF])                      // [RULE14]
		| (i_overtemp_det & ~mask_q[frm_pkg::B_TSD]);                      // [RULE15]

	assign wr_acc = i_psel & i_penable & i_pwrite;
	assign rd_acc = i_psel & ~i_penable & ~i_pwrite;

	////////////////////////////////////////////////////////////////////////
	// control registers
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			channel_diag_enable_q <= frm_pkg::DIAG_EN_RST;
			mask_q                <= frm_pkg::MASK_RST;
			irq_mask_q            <= '0;
		end else if (wr_acc) begin
			case (i_paddr)
				frm_pkg::A_DIAG_EN:     channel_diag_enable_q <= i_pwdata[N-1:0];
				frm_pkg::A_MASK_GLOBAL: mask_q <= i_pwdata[frm_pkg::NUM_MASK-1:0];
				frm_pkg::A_IRQ_MASK:    irq_mask_q <= i_pwdata[frm_pkg::NUM_IRQ-1:0];
				default: ;
			endcase
		end
	end

	// clear strobe self-returns after one cycle
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			fault_clear_strobe_q <= 1'b0;
		end else begin
			fault_clear_strobe_q <= wr_acc && (i_paddr == frm_pkg::A_CONTROL)
				&& i_pwdata[frm_pkg::B_CLR]; // [RULE13]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// latched flags; set wins over clear
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			channel_open_flag_q             <= '0;
			channel_short_flag_q            <= '0;
			channel_single_led_short_flag_q <= '0;
			glb_flag_q                      <= '0;
			out_flag_q                      <= 1'b0;
			err_flag_q                      <= 1'b0;
		end else if (fault_clear_strobe_q) begin
			channel_open_flag_q             <= open_ev;  // [RULE13]
			channel_short_flag_q            <= short_ev;
			channel_single_led_short_flag_q <= sls_ev;
			glb_flag_q                      <= glb_ev;
			out_flag_q                      <= out_ev;
			err_flag_q                      <= err_ev;
		end else begin
			channel_open_flag_q             <= channel_open_flag_q | open_ev; // [RULE12]
			channel_short_flag_q            <= channel_short_flag_q | short_ev;
			channel_single_led_short_flag_q <= channel_single_led_short_flag_q | sls_ev;
			glb_flag_q                      <= glb_flag_q | glb_ev;        // [RULE1]
			out_flag_q                      <= out_flag_q | out_ev;        // [RULE2]
			err_flag_q                      <= err_flag_q | err_ev;        // [RULE2]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// error pin: pulse counter plus continuous hold
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pulse_cnt_q <= '0;
		end else if (pulse_ev && pulse_cnt_q == '0) begin
			pulse_cnt_q <= frm_pkg::PCNT_W'(frm_pkg::PULSE_CYC); // [RULE16]
		end else if (pulse_cnt_q != '0) begin
			pulse_cnt_q <= pulse_cnt_q - 1'b1; // [RULE16]
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_err_oe <= 1'b0;
		end else begin
			o_err_oe <= hold_low || (pulse_cnt_q != '0) || (pulse_ev && pulse_cnt_q == '0); // [RULE6]
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_err_out <= 1'b0;
		end else begin
			o_err_out <= 1'b0;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_any_out_flag    <= 1'b0;
			o_global_err_flag <= 1'b0;
		end else begin
			o_any_out_flag    <= out_flag_q;
			o_global_err_flag <= err_flag_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: bit0 out roll-up event, bit1 error roll-up event
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			irq_status_q <= '0;
		end else begin
			for (int k = 0; k < frm_pkg::NUM_IRQ; k++) begin
				if ((k == 0) ? out_ev : err_ev) begin
					irq_status_q[k] <= 1'b1;
				end else if (wr_acc && i_paddr == frm_pkg::A_IRQ_STATUS && i_pwdata[k]) begin
					irq_status_q[k] <= 1'b0;
				end
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_irq <= 1'b0;
		end else begin
			o_irq <= |(irq_status_q & ~irq_mask_q);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb slave: no wait state, read data captured in setup
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_pready  <= 1'b0;
			o_pslverr <= 1'b0;
		end else begin
			o_pready  <= i_psel & ~i_penable;
			o_pslverr <= i_psel & ~i_penable & (i_paddr > frm_pkg::A_IRQ_MASK
				|| i_paddr[1:0] != 2'h0);
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_prdata <= '0;
		end else if (rd_acc) begin
			case (i_paddr)
				frm_pkg::A_DIAG_EN:     o_prdata <= 32'(channel_diag_enable_q);
				frm_pkg::A_MASK_GLOBAL: o_prdata <= 32'(mask_q);
				frm_pkg::A_FLAG_OPEN:   o_prdata <= 32'(channel_open_flag_q);
				frm_pkg::A_FLAG_SHORT:  o_prdata <= 32'(channel_short_flag_q);
				frm_pkg::A_FLAG_SLS:    o_prdata <= 32'(channel_single_led_short_flag_q);
				frm_pkg::A_FLAG_GLOBAL: o_prdata <= 32'({err_flag_q, out_flag_q, glb_flag_q});
				frm_pkg::A_CONTROL:     o_prdata <= 32'(fault_clear_strobe_q);
				frm_pkg::A_IRQ_STATUS:  o_prdata <= 32'(irq_status_q);
				frm_pkg::A_IRQ_MASK:    o_prdata <= 32'(irq_mask_q);
				default:                o_prdata <= '0;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions
	sequence s_pulse_start;
		!i_srst && pulse_ev && pulse_cnt_q == '0;
	endsequence

	a_flag_latches: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE12]
		channel_open_flag_q[0] && !fault_clear_strobe_q |=> channel_open_flag_q[0])
		else $error("open flag dropped without clear");
	a_own_flag_set: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE1]
		i_open_det[0] && channel_diag_enable_q[0] |=> channel_open_flag_q[0])
		else $error("open flag not set");
	a_diag_off_quiet: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE4]
		!channel_diag_enable_q[0] && !fault_clear_strobe_q && !channel_open_flag_q[0]
		|=> !channel_open_flag_q[0])
		else $error("disabled channel set flag");
	a_mask_blocks_err: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE2]
		(&mask_q) && !err_flag_q && !fault_clear_strobe_q |=> !err_flag_q)
		else $error("masked fault reached error flag");
	a_pulse_len: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE16]
		s_pulse_start |=> pulse_cnt_q == frm_pkg::PCNT_W'(frm_pkg::PULSE_CYC) ##1 o_err_oe)
		else $error("pulse not started");
	a_hold_low: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE14]
		hold_low |=> o_err_oe)
		else $error("held fault not driving pin");
	a_low_sup_mask: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE5]
		i_low_supply_det |=> glb_flag_q[frm_pkg::B_LOWSUP])
		else $error("low supply flag missing");
	a_clear_self: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE13]
		fault_clear_strobe_q && !wr_acc |=> !fault_clear_strobe_q)
		else $error("clear strobe stuck");
	a_pin_idle: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE8]
		!hold_low && !pulse_ev && pulse_cnt_q == '0 |=> !o_err_oe)
		else $error("pin driven without cause");

	// own flags, roll-ups, pulse counter and interrupt level
	a_short_flag_set: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE10]
		i_short_det[0] && channel_diag_enable_q[0] |=> channel_short_flag_q[0])
		else $error("short flag not set");
	a_sls_flag_set: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE11]
		i_sls_det[0] && channel_diag_enable_q[0] |=> channel_single_led_short_flag_q[0])
		else $error("single led short flag not set");
	a_out_roll_set: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE9]
		out_ev |=> out_flag_q)
		else $error("output roll-up not set");
	a_err_roll_set: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE2]
		err_ev |=> err_flag_q)
		else $error("error roll-up not set");
	a_out_mask_blocks: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE2]
		mask_q[frm_pkg::B_OPEN] && mask_q[frm_pkg::B_SHORT] && mask_q[frm_pkg::B_SLS]
		&& !out_flag_q |=> !out_flag_q)
		else $error("masked channel fault reached output roll-up");
	a_any_flag_copy: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE2]
		out_flag_q |=> o_any_out_flag)
		else $error("output roll-up pin copy missing");
	a_pulse_keep: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE16]
		pulse_cnt_q != '0 |=> o_err_oe)
		else $error("pin released during pulse");
	a_pulse_count_down: assert property (@(posedge i_clock) disable iff (i_srst) // [RULE16]
		pulse_cnt_q != '0 |=> pulse_cnt_q == $past(pulse_cnt_q) - 1'b1)
		else $error("pulse counter disturbed");
	a_irq_level: assert property (@(posedge i_clock) disable iff (i_srst)
		(|(irq_status_q & ~irq_mask_q)) |=> o_irq)
		else $error("interrupt not raised");
endmodule
`default_nettype wire

// file: hdl/frm_pkg.sv
// Purpose: constants for the fault report and masking block
// Assumes: 200 MHz device clock, APB register access
// Notes:   offsets are byte addresses of 32-bit words
package frm_pkg;
	localparam int          NUM_CH          = 24;
	localparam int          CLK_MHZ         = 200;
	localparam int          PULSE_US        = 50;
	localparam int          PULSE_CYC       = PULSE_US * CLK_MHZ;
	localparam int          PCNT_W          = 14;
	localparam logic [7:0]  A_DIAG_EN       = 8'h00;
	localparam logic [7:0]  A_MASK_GLOBAL   = 8'h04;
	localparam logic [7:0]  A_FLAG_OPEN     = 8'h08;
	localparam logic [7:0]  A_FLAG_SHORT    = 8'h0c;
	localparam logic [7:0]  A_FLAG_SLS      = 8'h10;
	localparam logic [7:0]  A_FLAG_GLOBAL   = 8'h14;
	localparam logic [7:0]  A_CONTROL       = 8'h18;
	localparam logic [7:0]  A_IRQ_STATUS    = 8'h1c;
	localparam logic [7:0]  A_IRQ_MASK      = 8'h20;
	// global mask / flag bit positions
	localparam int          B_LOWSUP        = 0;
	localparam int          B_SUPUV         = 1;
	localparam int          B_REF           = 2;
	localparam int          B_PRETSD        = 3;
	localparam int          B_TSD           = 4;
	localparam int          B_EEPCRC        = 5;
	localparam int          B_OPEN          = 6;
	localparam int          B_SHORT         = 7;
	localparam int          B_SLS           = 8;
	localparam int          NUM_GLB         = 6;
	localparam int          NUM_MASK        = 9;
	localparam int          B_OUT_FLAG      = 6;
	localparam int          B_ERR_FLAG      = 7;
	localparam int          B_CLR           = 0;
	localparam int          NUM_IRQ         = 2;
	localparam logic [23:0] DIAG_EN_RST     = 24'hffffff;
	localparam logic [8:0]  MASK_RST        = 9'h000;
endpackage

// file: test/frm_host_model.sv
// Purpose: host side of the error pin, pull-up and low-time meter
// Assumes: open drain pin, o_err_oe high pulls the line low
// Notes:   released pin reads high through the pull-up
`timescale 1ns/1ps
`default_nettype none
module frm_host_model (
	input  wire logic        i_clock,
	input  wire logic        i_err_oe,
	input  wire logic        i_err_out,
	output logic             o_err_n,
	output logic [15:0]      o_last_len,
	output logic [15:0]      o_low_total
);
	logic [15:0] run_q = 16'h0000;
	logic [15:0] last_q = 16'h0000;
	logic [15:0] total_q = 16'h0000;
	assign o_last_len = last_q;
	assign o_low_total = total_q;
	// pull-up: nobody driving means high
	assign o_err_n = i_err_oe ? i_err_out : 1'b1;
	////////////////////////////////////////////////////////////////
	always @(posedge i_clock) begin
		if (o_err_n === 1'b0) begin
			run_q <= run_q + 16'h0001;
			total_q <= total_q + 16'h0001;
		end else if (run_q != 16'h0000) begin
			last_q <= run_q;
			run_q <= 16'h0000;
		end
	end
endmodule
`default_nettype wire

// file: test/tb.sv
// Purpose: self-checking bench for the fault report block
// Assumes: one clock, APB register access, host pin model
// Notes:   pulse widths measured on the resolved pin
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic        i_clock = 1'b0;
	logic        i_srst = 1'b1;
	logic        i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [7:0]  i_paddr = 8'h00;
	logic [31:0] i_pwdata = 32'h0, o_prdata, rd, e;
	logic [23:0] i_open_det = 24'h0, i_short_det = 24'h0, i_sls_det = 24'h0;
	logic [5:0]  gdet = 6'h00;
	logic        o_pready, o_pslverr, o_err_oe, o_any_out_flag, o_global_err_flag, o_irq;
	logic        serr, err_n, err_out;
	logic [15:0] last_len, low_total;
	int          miscompares = 0, tests_run = 0;
	always #2.5 i_clock = ~i_clock;
	frm_core frm_core_inst (.i_clock, .i_srst, .i_psel, .i_penable, .i_pwrite,
		.i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr,
		.i_open_det, .i_short_det, .i_sls_det,
		.i_low_supply_det(gdet[0]), .i_supply_uv_det(gdet[1]),
		.i_ref_fault_det(gdet[2]), .i_pre_thermal_det(gdet[3]),
		.i_overtemp_det(gdet[4]), .i_eeprom_crc_det(gdet[5]),
		.o_err_oe, .o_err_out(err_out), .o_any_out_flag, .o_global_err_flag, .o_irq);
	frm_host_model frm_host_model_inst (.i_clock, .i_err_oe(o_err_oe), .i_err_out(err_out),
		.o_err_n(err_n), .o_last_len(last_len), .o_low_total(low_total));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge i_clock);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		@(posedge i_clock);
		i_penable <= 1'b1;
		@(posedge i_clock);
		while (o_pready !== 1'b1) begin
			@(posedge i_clock);
		end
		rd = o_prdata;
		serr = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		check(rd, exp);
	endtask
	task automatic fault(input int k, input int ch);
		@(posedge i_clock);
		if (k < 6) gdet[k] <= 1'b1;
		else if (k == 6) i_open_det[ch] <= 1'b1;
		else if (k == 7) i_short_det[ch] <= 1'b1;
		else i_sls_det[ch] <= 1'b1;
		@(posedge i_clock);
		gdet <= 6'h00;
		i_open_det <= 24'h0;
		i_short_det <= 24'h0;
		i_sls_det <= 24'h0;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		#450000;
		miscompares++;
		close_out();
	end
	initial begin
		int ks[6] = '{0, 3, 5, 6, 7, 8};
		int hs[3] = '{1, 2, 4};
		int n;
		cyc(4);
		i_srst <= 1'b0;
		rdchk(frm_pkg::A_DIAG_EN, {8'h00, frm_pkg::DIAG_EN_RST});
		rdchk(frm_pkg::A_MASK_GLOBAL, {23'h0, frm_pkg::MASK_RST});
		rdchk(frm_pkg::A_IRQ_STATUS, 32'h0);
		rdchk(8'h24, 32'h0);
		check({31'h0, serr}, 32'h1);
		apb(1'b1, frm_pkg::A_MASK_GLOBAL, 32'h1ff);
		for (int k = 0; k < 9; k++) fault(k, 0);
		cyc(4);
		rdchk(frm_pkg::A_FLAG_GLOBAL, 32'h3f);
		rdchk(frm_pkg::A_FLAG_OPEN, 32'h1);
		rdchk(frm_pkg::A_FLAG_SHORT, 32'h1);
		rdchk(frm_pkg::A_FLAG_SLS, 32'h1);
		check({14'h0, o_any_out_flag, o_global_err_flag, low_total}, 32'h0);
		apb(1'b1, frm_pkg::A_CONTROL, 32'h1);
		cyc(2);
		rdchk(frm_pkg::A_CONTROL, 32'h0);
		rdchk(frm_pkg::A_FLAG_SLS, 32'h0);
		apb(1'b1, frm_pkg::A_MASK_GLOBAL, 32'h0);
		apb(1'b1, frm_pkg::A_DIAG_EN, 32'h00fffffe);
		for (int k = 6; k < 9; k++) fault(k, 0);
		cyc(4);
		rdchk(frm_pkg::A_FLAG_OPEN, 32'h0);
		rdchk(frm_pkg::A_FLAG_GLOBAL, 32'h0);
		check({16'h0, low_total}, 32'h0);
		apb(1'b1, frm_pkg::A_DIAG_EN, 32'h00ffffff);
		foreach (ks[i]) begin
			apb(1'b1, frm_pkg::A_CONTROL, 32'h1);
			fault(ks[i], 2);
			cyc(4);
			e = (ks[i] < 6) ? (32'h80 | (32'h1 << ks[i])) : 32'hc0;
			rdchk(frm_pkg::A_FLAG_GLOBAL, e);
			check({30'h0, o_any_out_flag, o_global_err_flag}, {30'h0, ks[i] > 5, 1'b1});
			if (i == 0) begin
				check({31'h0, o_irq}, 32'h1);
				apb(1'b1, frm_pkg::A_IRQ_MASK, 32'h3);
				cyc(2);
				check({31'h0, o_irq}, 32'h0);
				apb(1'b1, frm_pkg::A_IRQ_MASK, 32'h0);
				rdchk(frm_pkg::A_IRQ_STATUS, 32'h2);
				apb(1'b1, frm_pkg::A_IRQ_STATUS, 32'h3);
				rdchk(frm_pkg::A_IRQ_STATUS, 32'h0);
				check({31'h0, o_irq}, 32'h0);
				cyc(5000);
				fault(7, 1);
			end
			check({31'h0, err_n}, 32'h0);
			n = 0;
			while (err_n !== 1'b1 && n < 11000) begin
				@(posedge i_clock);
				n++;
			end
			check({31'h0, err_n}, 32'h1);
			cyc(2);
			check({16'h0, last_len}, 32'(frm_pkg::PULSE_CYC + 1));
		end
		foreach (hs[i]) begin
			apb(1'b1, frm_pkg::A_CONTROL, 32'h1);
			@(posedge i_clock);
			gdet[hs[i]] <= 1'b1;
			cyc(20);
			check({31'h0, err_n}, 32'h0);
			rdchk(frm_pkg::A_FLAG_GLOBAL, 32'h80 | (32'h1 << hs[i]));
			gdet <= 6'h00;
			cyc(3);
			check({31'h0, err_n}, 32'h1);
		end
		close_out();
	end
endmodule
`default_nettype wire
